/* bcg_pkg.sv */
// Package for the bus clock gate mask bank: offsets, widths, reset values.
// Assumes a 32-bit APB slave port with byte addresses.
package bcg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned BCG_ADDR_W = 8;
  localparam logic [BCG_ADDR_W-1:0] BCG_SYS_OFS = 8'h14;
  localparam logic [BCG_ADDR_W-1:0] BCG_A_OFS = 8'h18;
  localparam logic [BCG_ADDR_W-1:0] BCG_B_OFS = 8'h1C;
  localparam logic [BCG_ADDR_W-1:0] BCG_C_OFS = 8'h20;

  // ----------------------------------------------------------------------
  // Number of defined gate enables per register
  // ----------------------------------------------------------------------
  localparam int unsigned BCG_SYS_W = 7;
  localparam int unsigned BCG_A_W = 7;
  localparam int unsigned BCG_B_W = 6;
  localparam int unsigned BCG_C_W = 11;

  // ----------------------------------------------------------------------
  // Reset values as printed, and masks of the defined bits
  // ----------------------------------------------------------------------
  localparam logic [31:0] BCG_SYS_RST = 32'h0000007F;
  localparam logic [31:0] BCG_A_RST = 32'h0000007F;
  localparam logic [31:0] BCG_B_RST = 32'h0000007F;
  localparam logic [31:0] BCG_C_RST = 32'h00000100;
  localparam logic [31:0] BCG_SYS_MASK = 32'h0000007F;
  localparam logic [31:0] BCG_A_MASK = 32'h0000007F;
  localparam logic [31:0] BCG_B_MASK = 32'h0000003F;
  localparam logic [31:0] BCG_C_MASK = 32'h000007FF;

  // ----------------------------------------------------------------------
  // Field positions of a few named clients
  // ----------------------------------------------------------------------
  localparam int unsigned BCG_SYS_USB_BIT = 6;
  localparam int unsigned BCG_SYS_DMA_CONTROLLER_BIT = 5;
  localparam int unsigned BCG_A_WATCHDOG_TIMER_BIT = 4;
  localparam int unsigned BCG_B_PORT_BIT = 3;
  localparam int unsigned BCG_C_SAMPLING_CONV_BIT = 8;

endpackage

/* bcg_gate_if.sv */
// Interface between the mask registers and one bank of clock gates.
// Assumes the source clock is derived from the register clock.
`timescale 1ns/1ps
interface bcg_gate_if #(
  parameter int unsigned N = 1
);
  logic src_clk;
  logic [N-1:0] en;
  logic [N-1:0] generic_clock_generator;
  modport ctrl (output src_clk, output en, input generic_clock_generator);
  modport gate (input src_clk, input en, output generic_clock_generator);
endinterface

/* bcg_clock_gate.sv */
// Bank of glitch-free clock gates, one per enable bit.
// Assumes enables change synchronously to the register clock.
`timescale 1ns/1ps
module bcg_clock_gate #(
  parameter int unsigned N = 1,
  parameter logic [31:0] RST = 32'h00000000
) (
  // Gate carrier
  bcg_gate_if.gate gif,
  // Reset
  input wire logic rst_n
);

  logic [N-1:0] en_q;

  // ----------------------------------------------------------------------
  // Per-bit gate
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < N; i++) begin : g_gate
      // Enable is taken on the falling edge, so outside reset it only moves while clock low
      always_ff @(negedge gif.src_clk or negedge rst_n) begin
        if (!rst_n) begin
          en_q[i] <= RST[i];
        end else begin
          en_q[i] <= gif.en[i];
        end
      end
      // High phase is passed whole or not at all, unless rst_n falls during it
      assign gif.generic_clock_generator[i] = gif.src_clk & en_q[i];
    end
  endgenerate

endmodule

/* bcg_clock_gates.sv */
// Bus clock gate mask bank: four APB-mapped masks that gate bus clients.
// Assumes an APB master on pclk and source clocks derived from pclk.
//
// Functional notes
// - System-bus mask at 0x14, resets 0x7F
// - Bits 6..4 gate USB, DMA, memory controller
// - Bit 3 debug unit, bits 2..0 bridges
// - Bus-A mask at 0x18, resets 0x7F
// - Bits 6..4 gate interrupts, RTC, watchdog
// - Bits 3..0 clockgen, system_controller, power, protection
// - Bus-B mask at 0x1C, bits 5..0
// - Bits 5..3 gate USB, DMA, port
// - Bits 2..0 memory controller, debug, protection
// - Bus-C mask at 0x20, eleven enables, 0x100
// - Undefined upper bits always read zero
`timescale 1ns/1ps
module bcg_clock_gates
  import bcg_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic [BCG_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source clocks
  input wire logic sys_clk_src,
  input wire logic bus_a_clk_src,
  input wire logic bus_b_clk_src,
  input wire logic bus_c_clk_src,
  // Gated clocks
  output logic [BCG_SYS_W-1:0] sys_generic_clock_generator,
  output logic [BCG_A_W-1:0] bus_a_generic_clock_generator,
  output logic [BCG_B_W-1:0] bus_b_generic_clock_generator,
  output logic [BCG_C_W-1:0] bus_c_generic_clock_generator
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [31:0] system_bus_clock_gates_q;
  logic [31:0] bus_a_clock_gates_q;
  logic [31:0] bus_b_clock_gates_q;
  logic [31:0] bus_c_clock_gates_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Decode results
  logic hit_sys;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_any;
  logic [31:0] rd_val;
  logic [31:0] lane_mask;
  logic wr_go;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (BCG_ADDR_W < 6) begin : g_chk_addr
    $error("Address width too small for the register map");
  end
  if (BCG_C_W > 32) begin : g_chk_w
    $error("Gate bank wider than a data word");
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Pick the addressed register; undefined bits are already zero in it
  always_comb begin
    hit_sys = 1'b0;
    hit_a = 1'b0;
    hit_b = 1'b0;
    hit_c = 1'b0;
    rd_val = 32'h00000000;
    if (paddr == BCG_SYS_OFS) begin
      hit_sys = 1'b1;
      rd_val = system_bus_clock_gates_q;
    end else if (paddr == BCG_A_OFS) begin
      hit_a = 1'b1;
      rd_val = bus_a_clock_gates_q;
    end else if (paddr == BCG_B_OFS) begin
      hit_b = 1'b1;
      rd_val = bus_b_clock_gates_q;
    end else if (paddr == BCG_C_OFS) begin
      hit_c = 1'b1;
      rd_val = bus_c_clock_gates_q;
    end
  end

  assign hit_any = hit_sys | hit_a | hit_b | hit_c;

  // Byte lanes from the write strobes
  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[8*b +: 8] = {8{pstrb[b]}};
    end
  endgenerate

  // Write commits at the completing edge of the access phase
  assign wr_go = psel & penable & pready_q & pwrite & hit_any;

  // Merge the enabled byte lanes and drop undefined bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] defined);
    merge = ((old & ~lane_mask) | (pwdata & lane_mask)) & defined;
  endfunction

  // ----------------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------------
  // System-bus clock mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_bus_clock_gates_q <= BCG_SYS_RST;
    end else if (wr_go && hit_sys) begin
      system_bus_clock_gates_q <= merge(system_bus_clock_gates_q, BCG_SYS_MASK);
    end
  end

  // Bus-A clock mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_a_clock_gates_q <= BCG_A_RST;
    end else if (wr_go && hit_a) begin
      bus_a_clock_gates_q <= merge(bus_a_clock_gates_q, BCG_A_MASK);
    end
  end

  // Bus-B clock mask; printed reset trimmed to the defined bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_b_clock_gates_q <= BCG_B_RST & BCG_B_MASK;
    end else if (wr_go && hit_b) begin
      bus_b_clock_gates_q <= merge(bus_b_clock_gates_q, BCG_B_MASK);
    end
  end

  // Bus-C clock mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_c_clock_gates_q <= BCG_C_RST;
    end else if (wr_go && hit_c) begin
      bus_c_clock_gates_q <= merge(bus_c_clock_gates_q, BCG_C_MASK);
    end
  end

  // ----------------------------------------------------------------------
  // APB answer: one wait state, then a single ready cycle
  // ----------------------------------------------------------------------
  // Ready rises after the first access cycle and falls after completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
    end
  end

  // Error flag for an address outside the map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= psel & penable & ~pready_q & ~hit_any;
    end
  end

  // Read data captured with ready; zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && penable && !pready_q && !pwrite) begin
      prdata_q <= rd_val;
    end else begin
      prdata_q <= 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------------
  // Clock gate banks
  // ----------------------------------------------------------------------
  bcg_gate_if #(.N(BCG_SYS_W)) sys_if ();
  bcg_gate_if #(.N(BCG_A_W)) a_if ();
  bcg_gate_if #(.N(BCG_B_W)) b_if ();
  bcg_gate_if #(.N(BCG_C_W)) c_if ();

  // Enables straight from the mask registers
  assign sys_if.src_clk = sys_clk_src;
  assign sys_if.en = system_bus_clock_gates_q[BCG_SYS_W-1:0];
  assign a_if.src_clk = bus_a_clk_src;
  assign a_if.en = bus_a_clock_gates_q[BCG_A_W-1:0];
  assign b_if.src_clk = bus_b_clk_src;
  assign b_if.en = bus_b_clock_gates_q[BCG_B_W-1:0];
  assign c_if.src_clk = bus_c_clk_src;
  assign c_if.en = bus_c_clock_gates_q[BCG_C_W-1:0];

  bcg_clock_gate #(.N(BCG_SYS_W), .RST(BCG_SYS_RST)) u_sys_gate (
    .gif(sys_if),
    .rst_n(presetn)
  );
  bcg_clock_gate #(.N(BCG_A_W), .RST(BCG_A_RST)) u_a_gate (
    .gif(a_if),
    .rst_n(presetn)
  );
  bcg_clock_gate #(.N(BCG_B_W), .RST(BCG_B_RST & BCG_B_MASK)) u_b_gate (
    .gif(b_if),
    .rst_n(presetn)
  );
  bcg_clock_gate #(.N(BCG_C_W), .RST(BCG_C_RST)) u_c_gate (
    .gif(c_if),
    .rst_n(presetn)
  );

  // Gated clocks leave through the gate banks
  assign sys_generic_clock_generator = sys_if.generic_clock_generator;
  assign bus_a_generic_clock_generator = a_if.generic_clock_generator;
  assign bus_b_generic_clock_generator = b_if.generic_clock_generator;
  assign bus_c_generic_clock_generator = c_if.generic_clock_generator;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A write that completes with every lane strobed
  sequence s_full_wr(logic hit);
    psel && penable && pready_q && pwrite && hit && (pstrb == 4'hF);
  endsequence

  // First access cycle of a transfer
  sequence s_access_start;
    psel && penable && !pready_q;
  endsequence

  property p_wr_sys;
    s_full_wr(hit_sys) |=> system_bus_clock_gates_q == ($past(pwdata) & BCG_SYS_MASK);
  endproperty
  a_wr_sys: assert property (p_wr_sys) else $error("system-bus mask write lost");

  property p_wr_a;
    s_full_wr(hit_a) |=> bus_a_clock_gates_q == ($past(pwdata) & BCG_A_MASK);
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("bus-A mask write lost");

  property p_wr_b;
    s_full_wr(hit_b) |=> bus_b_clock_gates_q == ($past(pwdata) & BCG_B_MASK);
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("bus-B mask write lost");

  property p_wr_c;
    s_full_wr(hit_c) |=> bus_c_clock_gates_q == ($past(pwdata) & BCG_C_MASK);
  endproperty
  a_wr_c: assert property (p_wr_c) else $error("bus-C mask write lost");

  property p_rsvd_rd;
    pready_q && !pslverr_q |-> (prdata_q & ~BCG_C_MASK) == 32'h00000000;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits read nonzero");

  property p_b_upper;
    (bus_b_clock_gates_q & ~BCG_B_MASK) == 32'h00000000;
  endproperty
  a_b_upper: assert property (p_b_upper) else $error("bus-B undefined bit set");

  property p_ready_once;
    s_access_start ##1 (psel && penable) |-> pready_q ##1 !pready_q;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready not a single pulse");

  property p_unmapped;
    psel && penable && !pready_q && !hit_any |=> pslverr_q && pready_q;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  property p_no_stray_wr;
    !(psel && penable && pready_q && pwrite) |=> $stable(system_bus_clock_gates_q)
      && $stable(bus_a_clock_gates_q) && $stable(bus_b_clock_gates_q)
      && $stable(bus_c_clock_gates_q);
  endproperty
  a_no_stray_wr: assert property (p_no_stray_wr) else $error("mask changed without write");

  property p_rd_sys;
    psel && penable && !pready_q && !pwrite && hit_sys
      |=> prdata_q == $past(system_bus_clock_gates_q);
  endproperty
  a_rd_sys: assert property (p_rd_sys) else $error("system-bus read data wrong");

endmodule

/* bcg_client_model.sv */
// Model of the bus clients that receive one bank of gated clocks.
// Assumes the source clock is pclk itself, so one full pulse lasts 20 ns high.
`timescale 1ns/1ps
module bcg_client_model #(
  parameter int unsigned N = 1
) (
  // Reference clock and bench control
  input wire logic pclk,
  input wire logic clr,
  // Clock tree
  output logic src_clk,
  input wire logic [N-1:0] generic_clock_generator,
  // Observations
  output logic [N-1:0] seen,
  output logic [N-1:0] short_pulse
);
  // -------------------------------------------------------------------
  // Source clock
  // -------------------------------------------------------------------
  // Derived from pclk with a divide by one, so no crossing hazard
  assign src_clk = pclk;

  // -------------------------------------------------------------------
  // Per-client edge and pulse-width monitors
  // -------------------------------------------------------------------
  initial short_pulse = '0;
  for (genvar i = 0; i < N; i++) begin : g_cl
    realtime t_rise = 0.0;
    // A client notes that its clock ran since the last clear
    always @(posedge generic_clock_generator[i] or posedge clr) begin
      if (clr) seen[i] <= 1'b0;
      else seen[i] <= 1'b1;
    end
    // A high phase cut short would upset a real client's flops
    always @(posedge generic_clock_generator[i]) t_rise = $realtime;
    always @(negedge generic_clock_generator[i]) begin
      if (t_rise > 0.0 && $realtime - t_rise < 19.0) short_pulse[i] = 1'b1;
    end
  end
endmodule

/* testbench.sv */
// Self-checking bench for the bus clock gate mask bank.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench
  import bcg_pkg::*;
;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, clr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic s_src, a_src, b_src, c_src;
  logic [6:0] s_g, a_g, s_seen, a_seen, s_sh, a_sh;
  logic [5:0] b_g, b_seen, b_sh;
  logic [10:0] c_g, c_seen, c_sh;
  logic [31:0] exp_q [4];
  int n_fail = 0;
  int checks_done = 0;
  int seed = 32'h74b0;

  // Clock of 40 ns period
  always #20 pclk = ~pclk;

  bcg_clock_gates u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_clk_src(s_src), .bus_a_clk_src(a_src),
    .bus_b_clk_src(b_src), .bus_c_clk_src(c_src), .sys_generic_clock_generator(s_g), .bus_a_generic_clock_generator(a_g),
    .bus_b_generic_clock_generator(b_g), .bus_c_generic_clock_generator(c_g));
  bcg_client_model #(.N(7)) u_sys (.pclk(pclk), .clr(clr), .src_clk(s_src), .generic_clock_generator(s_g),
    .seen(s_seen), .short_pulse(s_sh));
  bcg_client_model #(.N(7)) u_a (.pclk(pclk), .clr(clr), .src_clk(a_src), .generic_clock_generator(a_g),
    .seen(a_seen), .short_pulse(a_sh));
  bcg_client_model #(.N(6)) u_b (.pclk(pclk), .clr(clr), .src_clk(b_src), .generic_clock_generator(b_g),
    .seen(b_seen), .short_pulse(b_sh));
  bcg_client_model #(.N(11)) u_c (.pclk(pclk), .clr(clr), .src_clk(c_src), .generic_clock_generator(c_g),
    .seen(c_seen), .short_pulse(c_sh));

  // -------------------------------------------------------------------
  // Expectation helpers
  // -------------------------------------------------------------------
  function automatic logic [7:0] adr(int i);
    return i == 0 ? BCG_SYS_OFS : i == 1 ? BCG_A_OFS : i == 2 ? BCG_B_OFS : BCG_C_OFS;
  endfunction
  function automatic logic [31:0] msk(int i);
    return i == 0 ? BCG_SYS_MASK : i == 1 ? BCG_A_MASK : i == 2 ? BCG_B_MASK : BCG_C_MASK;
  endfunction
  function automatic logic [31:0] rst(int i);
    return msk(i) & (i == 0 ? BCG_SYS_RST : i == 1 ? BCG_A_RST : i == 2 ? BCG_B_RST : BCG_C_RST);
  endfunction
  function automatic logic [31:0] seen_of(int i);
    return i == 0 ? 32'(s_seen) : i == 1 ? 32'(a_seen) : i == 2 ? 32'(b_seen) : 32'(c_seen);
  endfunction
  // Byte-lane merge, undefined bits dropped
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s, int i);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b +: 8] = d[8*b +: 8];
    end
    return o & msk(i);
  endfunction

  // -------------------------------------------------------------------
  // Closing report
  // -------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // APB master: setup, access, wait for pready under a bound
  // -------------------------------------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s; psel <= 1'b1; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      $display("Error pready expected 1 seen timeout");
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Clear the client monitors, let the gates run, compare with the mask
  task automatic chk_gates(int i);
    repeat (2) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("gated clocks", exp_q[i], seen_of(i))
  endtask

  task automatic rd_chk(int i);
    logic [31:0] rd;
    logic err;
    apb(adr(i), 1'b0, 32'h0, 4'h0, rd, err);
    `CHK("read data", exp_q[i], rd)
    `CHK("read error", 1'b0, err)
  endtask

  task automatic wr_chk(int i, logic [31:0] d, logic [3:0] s);
    logic [31:0] rd;
    logic err;
    apb(adr(i), 1'b1, d, s, rd, err);
    `CHK("write error", 1'b0, err)
    exp_q[i] = merge(exp_q[i], d, s, i);
    rd_chk(i);
    chk_gates(i);
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    logic [31:0] d, rd;
    logic [3:0] s;
    logic err;
    int i;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; clr = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and the clocks they enable
    for (i = 0; i < 4; i++) begin
      exp_q[i] = rst(i);
      rd_chk(i);
      chk_gates(i);
    end
    // Walk a single enable through every defined bit of every mask
    for (i = 0; i < 4; i++) begin
      for (int b = 0; b < 11; b++) begin
        if (((msk(i) >> b) & 32'h1) != 32'h0) wr_chk(i, 32'h1 << b, 4'hF);
      end
    end
    // Random writes; every fourth sets undefined bits and odd strobes
    for (int k = 0; k < 40; k++) begin
      i = $random(seed) & 3;
      d = $random(seed);
      s = 4'hF;
      if (k % 4 == 0) s = 4'($random(seed));
      else d = d & msk(i);
      wr_chk(i, d, s);
    end
    // Unmapped places are refused and leave the masks alone
    apb(8'h24, 1'b1, 32'hFFFFFFFF, 4'hF, rd, err);
    `CHK("unmapped write error", 1'b1, err)
    apb(8'h10, 1'b0, 32'h0, 4'h0, rd, err);
    `CHK("unmapped read error", 1'b1, err)
    `CHK("unmapped read data", 32'h0, rd)
    for (i = 0; i < 4; i++) rd_chk(i);
    `CHK("short pulses", 31'h0, {s_sh, a_sh, b_sh, c_sh})
    give_verdict();
  end
endmodule
